// file: src/sst_top.sv
// safety stop test sequencer: self-test supervision, timed stop, safety settings
// ******************************
// What this block does
// [R1] run torque shut-off self-test each time supply power comes up
// [R2] run the self-test each time safe torque removal is selected
// [R3] with brake relay module fitted the test also exercises its circuits
// [R4] self-test monitoring period is programmable, default eight hours
// [R5] remaining time until the next self-test is readable
// [R6] status bit is one while a self-test is required
// [R7] test-due warning raised without touching normal drive operation
// [R8] on the warning the controller stops motor, then removes torque or cycles supply
// [R9] safe stop one decelerates the motor with the fast-stop ramp time
// [R10] when the stop delay expires torque is removed whatever the speed
// [R11] the configurer sets the stop delay longer than the fast-stop ramp time
// [R12] brake control enable: zero locks safe brake control, one enables it
// [R13] writing 57 hex to the copy register builds the redundant image
// [R14] writing ac hex to the confirm register confirms the settings change
// [R15] password defaults to zero and accepts only 1 to ffff ffff hex
// [R16] with default password activation demands a new password first
// [R17] an impermissible new password is refused and the old one kept
// [R18] activated settings apply only after supply off and on again
// [R19] status bit is one while safe torque removal is active
// [R20] a passed self-test reloads the timer and clears flag and warning
// ******************************
`timescale 1ns/1ps
module sst_top #(
  parameter int MS_CYCLES = sst_pkg::MS_CYCLES_DEF
) (
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rd_data_out,
  // pins from the drive
  input  wire logic        supply_good_in,
  input  wire logic        safe_torque_removal_sel_in,
  input  wire logic        safe_stop_one_sel_in,
  input  wire logic        path_ok_in,
  input  wire logic        brake_ok_in,
  input  wire logic        brake_fitted_in,
  // drive control
  output logic             safe_torque_removal_out,
  output logic             fast_stop_out,
  output logic      [31:0] fast_stop_ramp_time_out,
  output logic             path_test_out,
  output logic             brake_test_out,
  output logic             brake_ctrl_enable_out,
  // status to the controller
  output logic             selftest_required_flag_out,
  output logic             selftest_due_warning_out,
  output logic             torque_removed_flag_out
);
  // ******************************
  // declarations
  // ******************************
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  logic [sst_pkg::SYNC_W-1:0] pin_s;
  logic [sst_pkg::SYNC_W-1:0] pin_d_reg;
  logic [sst_pkg::SYNC_W-1:0] rise;
  logic [15:0]                ms_cnt_reg;
  logic [9:0]                 sec_cnt_reg;
  logic                       ms_tick;
  logic                       sec_tick;
  sst_pkg::sst_state_t        state_reg;
  logic                       test_done;
  logic                       start_test;
  logic [31:0]                time_left;
  logic                       st_expire;
  logic [31:0]                dly_cnt;
  logic                       stop_off_reg;
  sst_pkg::sst_cfg_t          pend_reg;
  sst_pkg::sst_cfg_t          image_reg;
  sst_pkg::sst_cfg_t          commit_reg;
  sst_pkg::sst_cfg_t          act_reg;
  logic                       image_ok_reg;
  logic [31:0]                copy_reg;
  logic [31:0]                confirm_reg;
  logic [31:0]                pw_reg;
  logic [31:0]                pw_new_reg;
  logic                       unlock_reg;
  logic                       pw_need_reg;
  logic                       pw_rej_reg;
  logic                       pw_ok;
  logic [31:0]                status;
  logic [31:0]                rd_next;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    wr_hit = wr && a == off;
  endfunction

  // ******************************
  // pin synchronisers and edges
  // ******************************
  sst_sync u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .d_in   ({brake_fitted_in, brake_ok_in, path_ok_in,
              safe_stop_one_sel_in, safe_torque_removal_sel_in, supply_good_in}),
    .q_out  (pin_s)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_d_reg <= '0;
    end else if (ce_in) begin
      pin_d_reg <= pin_s;
    end
  end

  assign rise = pin_s & ~pin_d_reg;

  // ******************************
  // millisecond and second ticks
  // ******************************
  assign ms_tick  = ms_cnt_reg == MS_LAST;
  assign sec_tick = ms_tick && sec_cnt_reg == sst_pkg::MS_PER_S - 10'h001;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ms_cnt_reg  <= 16'h0000;
      sec_cnt_reg <= 10'h000;
    end else if (ce_in) begin
      ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
      if (sec_tick) begin
        sec_cnt_reg <= 10'h000;
      end else if (ms_tick) begin
        sec_cnt_reg <= sec_cnt_reg + 10'h001;
      end
    end
  end

  // ******************************
  // self-test sequence
  // ******************************
  assign start_test = rise[sst_pkg::IN_SUPPLY] | rise[sst_pkg::IN_TORQUE_SEL]; // [R1] [R2]
  assign test_done  = state_reg == sst_pkg::TS_TEST && pin_s[sst_pkg::IN_PATH_OK] &&
                      (pin_s[sst_pkg::IN_BRAKE_OK] || !pin_s[sst_pkg::IN_BRAKE_FIT]); // [R3]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg      <= sst_pkg::TS_IDLE;
      path_test_out  <= 1'b0;
      brake_test_out <= 1'b0;
    end else if (ce_in) begin
      case (state_reg)
        sst_pkg::TS_IDLE: begin
          if (start_test) begin
            state_reg <= sst_pkg::TS_TEST; // [R1] [R2]
          end
        end
        sst_pkg::TS_TEST: begin
          if (test_done) begin
            state_reg <= sst_pkg::TS_IDLE;
          end
        end
        default: begin
          state_reg <= sst_pkg::TS_IDLE;
        end
      endcase
      path_test_out  <= state_reg == sst_pkg::TS_TEST && !test_done;
      brake_test_out <= state_reg == sst_pkg::TS_TEST && !test_done &&
                        pin_s[sst_pkg::IN_BRAKE_FIT]; // [R3]
    end
  end

  // monitoring timer in seconds
  sst_timer u_test_timer (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .load_in     (test_done), // [R20]
    .load_val_in (act_reg.period), // [R4]
    .tick_in     (sec_tick),
    .count_out   (time_left), // [R5]
    .expire_out  (st_expire)
  );

  // expiry sets, a passed test clears; the set wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      selftest_required_flag_out <= 1'b1;
      selftest_due_warning_out   <= 1'b0;
    end else if (ce_in) begin
      if (st_expire) begin
        selftest_required_flag_out <= 1'b1; // [R6]
        selftest_due_warning_out   <= 1'b1; // [R7]
      end else if (test_done) begin
        selftest_required_flag_out <= 1'b0; // [R20]
        selftest_due_warning_out   <= 1'b0; // [R20]
      end
    end
  end

  // ******************************
  // safe stop one and torque removal
  // ******************************
  sst_timer u_stop_timer (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .load_in     (rise[sst_pkg::IN_STOP_SEL]),
    .load_val_in (act_reg.delay),
    .tick_in     (ms_tick),
    .count_out   (dly_cnt),
    .expire_out  ()
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_stop_out           <= 1'b0;
      fast_stop_ramp_time_out <= sst_pkg::RAMP_TIME_DEF;
      stop_off_reg            <= 1'b0;
    end else if (ce_in) begin
      fast_stop_out <= pin_s[sst_pkg::IN_STOP_SEL]; // [R9]
      if (!pin_s[sst_pkg::IN_STOP_SEL]) begin
        stop_off_reg <= 1'b0;
      end else if (fast_stop_out && dly_cnt == sst_pkg::TIMER_RST) begin
        stop_off_reg <= 1'b1; // [R10]
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_RAMP)) begin
        fast_stop_ramp_time_out <= wr_data_in; // [R9]
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      safe_torque_removal_out <= 1'b0;
      torque_removed_flag_out <= 1'b0;
      brake_ctrl_enable_out   <= 1'b0;
    end else if (ce_in) begin
      safe_torque_removal_out <= pin_s[sst_pkg::IN_TORQUE_SEL] | stop_off_reg |
                                 (state_reg == sst_pkg::TS_TEST); // [R10]
      torque_removed_flag_out <= pin_s[sst_pkg::IN_TORQUE_SEL] | stop_off_reg |
                                 (state_reg == sst_pkg::TS_TEST); // [R19]
      brake_ctrl_enable_out   <= act_reg.brake; // [R12]
    end
  end

  // ******************************
  // safety settings and password
  // ******************************
  assign pw_ok = wr_data_in == pw_new_reg && wr_data_in != sst_pkg::PW_RST &&
                 (unlock_reg || pw_reg == sst_pkg::PW_RST); // [R15]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg     <= sst_pkg::CFG_RST;
      image_reg    <= sst_pkg::CFG_RST;
      image_ok_reg <= 1'b0;
      copy_reg     <= sst_pkg::KEY_RST;
      confirm_reg  <= sst_pkg::KEY_RST;
      commit_reg   <= sst_pkg::CFG_RST;
      act_reg      <= sst_pkg::CFG_RST;
    end else if (ce_in) begin
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_PERIOD)) begin
        pend_reg.period <= wr_data_in; // [R4]
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_DELAY)) begin
        pend_reg.delay <= wr_data_in;
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_BRAKE)) begin
        pend_reg.brake <= wr_data_in[0]; // [R12]
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_COPY)) begin
        copy_reg <= wr_data_in;
        if (wr_data_in == sst_pkg::COPY_KEY) begin
          image_reg    <= pend_reg; // [R13]
          image_ok_reg <= 1'b1; // [R13]
        end
      end else if (wr_hit(wr_in, addr_in, sst_pkg::OFF_PERIOD) ||
                   wr_hit(wr_in, addr_in, sst_pkg::OFF_DELAY) ||
                   wr_hit(wr_in, addr_in, sst_pkg::OFF_BRAKE)) begin
        image_ok_reg <= 1'b0;
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_CONFIRM)) begin
        confirm_reg <= wr_data_in;
        if (wr_data_in == sst_pkg::CONFIRM_KEY && image_ok_reg && unlock_reg &&
            pw_reg != sst_pkg::PW_RST) begin
          commit_reg <= image_reg; // [R14] [R16]
        end
      end
      if (rise[sst_pkg::IN_SUPPLY]) begin
        act_reg <= commit_reg; // [R18]
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pw_reg      <= sst_pkg::PW_RST;
      pw_new_reg  <= sst_pkg::PW_RST;
      unlock_reg  <= 1'b0;
      pw_need_reg <= 1'b0;
      pw_rej_reg  <= 1'b0;
    end else if (ce_in) begin
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_PW_ENTRY)) begin
        unlock_reg <= wr_data_in == pw_reg && wr_data_in != sst_pkg::PW_RST;
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_PW_NEW)) begin
        pw_new_reg <= wr_data_in;
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_PW_CONFIRM)) begin
        pw_rej_reg <= !pw_ok; // [R17]
        if (pw_ok) begin
          pw_reg      <= wr_data_in; // [R15]
          pw_need_reg <= 1'b0;
        end
      end
      if (wr_hit(wr_in, addr_in, sst_pkg::OFF_CONFIRM) && wr_data_in == sst_pkg::CONFIRM_KEY &&
          pw_reg == sst_pkg::PW_RST) begin
        pw_need_reg <= 1'b1; // [R16]
      end
    end
  end

  // ******************************
  // register read port
  // ******************************
  always_comb begin
    status = 32'h0000_0000;
    status[sst_pkg::ST_TORQUE_OFF]  = torque_removed_flag_out; // [R19]
    status[sst_pkg::ST_REQUIRED]    = selftest_required_flag_out;
    status[sst_pkg::ST_WARNING]     = selftest_due_warning_out;
    status[sst_pkg::ST_TEST_BUSY]   = state_reg == sst_pkg::TS_TEST;
    status[sst_pkg::ST_PW_NEEDED]   = pw_need_reg;
    status[sst_pkg::ST_PW_REJECT]   = pw_rej_reg;
    status[sst_pkg::ST_RESTART_DUE] = commit_reg != act_reg;
    status[sst_pkg::ST_IMAGE_OK]    = image_ok_reg;
    status[sst_pkg::ST_BRAKE_EN]    = act_reg.brake;
    case (addr_in)
      sst_pkg::OFF_PERIOD:    rd_next = pend_reg.period;
      sst_pkg::OFF_DELAY:     rd_next = pend_reg.delay;
      sst_pkg::OFF_BRAKE:     rd_next = {31'h0000_0000, pend_reg.brake};
      sst_pkg::OFF_RAMP:      rd_next = fast_stop_ramp_time_out;
      sst_pkg::OFF_COPY:      rd_next = copy_reg;
      sst_pkg::OFF_CONFIRM:   rd_next = confirm_reg;
      sst_pkg::OFF_STATUS:    rd_next = status;
      sst_pkg::OFF_TIME_LEFT: rd_next = time_left; // [R5]
      default:                rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0000_0000;
    end else if (ce_in) begin
      rd_data_out <= rd_in ? rd_next : 32'h0000_0000;
    end
  end

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_power_test_start: assert property (ce_in && rise[sst_pkg::IN_SUPPLY] && // [R1]
    state_reg == sst_pkg::TS_IDLE |=> state_reg == sst_pkg::TS_TEST)
    else $error("no test at power");
  a_torque_test_start: assert property (ce_in && rise[sst_pkg::IN_TORQUE_SEL] && // [R2]
    state_reg == sst_pkg::TS_IDLE |=> state_reg == sst_pkg::TS_TEST)
    else $error("no test on torque removal");
  a_brake_test_on: assert property (ce_in && state_reg == sst_pkg::TS_TEST && !test_done && // [R3]
    pin_s[sst_pkg::IN_BRAKE_FIT] |=> brake_test_out) else $error("brake not tested");
  a_expire_flags: assert property (st_expire |=> selftest_required_flag_out && // [R6]
    selftest_due_warning_out) else $error("expiry not flagged");
  a_warn_no_stop: assert property (ce_in && !pin_s[sst_pkg::IN_TORQUE_SEL] && !stop_off_reg && // [R7]
    state_reg == sst_pkg::TS_IDLE |=> !safe_torque_removal_out) else $error("warning hit drive");
  a_stop_ramp_on: assert property (ce_in && rise[sst_pkg::IN_STOP_SEL] |=> fast_stop_out) // [R9]
    else $error("no fast stop");
  a_stop_torque_off: assert property (ce_in && stop_off_reg |=> // [R10]
    safe_torque_removal_out && torque_removed_flag_out) else $error("torque kept after delay");
  a_copy_image: assert property (ce_in && wr_hit(wr_in, addr_in, sst_pkg::OFF_COPY) && // [R13]
    wr_data_in == sst_pkg::COPY_KEY |=> image_ok_reg && image_reg == $past(pend_reg))
    else $error("copy not made");
  a_pw_zero_refused: assert property (ce_in && // [R17]
    wr_hit(wr_in, addr_in, sst_pkg::OFF_PW_CONFIRM) && wr_data_in == sst_pkg::PW_RST |=>
    $stable(pw_reg) && pw_rej_reg) else $error("bad pw taken");
  a_reload_on_pass: assert property (ce_in && test_done |=> // [R20]
    time_left == $past(act_reg.period) && !selftest_required_flag_out) else $error("no reload");

  c_test_pass: cover property (state_reg == sst_pkg::TS_TEST ##[1:20] test_done);
  c_stop_delay: cover property (rise[sst_pkg::IN_STOP_SEL] ##[1:200] stop_off_reg);
  c_pw_set: cover property (wr_hit(wr_in, addr_in, sst_pkg::OFF_PW_CONFIRM) && pw_ok);
endmodule

// file: common/sst_pkg.sv
// constants and types shared by the safety stop test sequencer
package sst_pkg;
  // ******************************
  // timing
  // ******************************
  localparam int          CLK_PERIOD_NS     = 25;
  localparam int          MS_NS             = 1000000;
  localparam int          MS_CYCLES_DEF     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  MS_PER_S          = 10'h3e8;
  localparam int          S_PER_H           = 3600;
  localparam int          SELFTEST_PERIOD_H = 8;
  localparam logic [31:0] SELFTEST_PERIOD_DEF = 32'(SELFTEST_PERIOD_H * S_PER_H);
  localparam logic [31:0] STOP_DELAY_DEF    = 32'h0000_0000;
  localparam logic [31:0] RAMP_TIME_DEF     = 32'h0000_0000;
  localparam logic [31:0] TIMER_RST         = 32'h0000_0000;

  // ******************************
  // register map
  // ******************************
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] OFF_PERIOD      = 8'h00;
  localparam logic [7:0] OFF_DELAY       = 8'h04;
  localparam logic [7:0] OFF_BRAKE       = 8'h08;
  localparam logic [7:0] OFF_RAMP        = 8'h0c;
  localparam logic [7:0] OFF_COPY        = 8'h10;
  localparam logic [7:0] OFF_CONFIRM     = 8'h14;
  localparam logic [7:0] OFF_PW_ENTRY    = 8'h18;
  localparam logic [7:0] OFF_PW_NEW      = 8'h1c;
  localparam logic [7:0] OFF_PW_CONFIRM  = 8'h20;
  localparam logic [7:0] OFF_STATUS      = 8'h24;
  localparam logic [7:0] OFF_TIME_LEFT   = 8'h28;

  // ******************************
  // keys, reset values, status bits
  // ******************************
  localparam logic [31:0] COPY_KEY     = 32'h0000_0057;
  localparam logic [31:0] CONFIRM_KEY  = 32'h0000_00ac;
  localparam logic [31:0] KEY_RST      = 32'h0000_0000;
  localparam logic [31:0] PW_RST       = 32'h0000_0000;
  localparam int ST_TORQUE_OFF  = 0;
  localparam int ST_REQUIRED    = 1;
  localparam int ST_WARNING     = 2;
  localparam int ST_TEST_BUSY   = 3;
  localparam int ST_PW_NEEDED   = 4;
  localparam int ST_PW_REJECT   = 5;
  localparam int ST_RESTART_DUE = 6;
  localparam int ST_IMAGE_OK    = 7;
  localparam int ST_BRAKE_EN    = 8;

  // ******************************
  // pin inputs
  // ******************************
  localparam int SYNC_W       = 6;
  localparam int IN_SUPPLY    = 0;
  localparam int IN_TORQUE_SEL = 1;
  localparam int IN_STOP_SEL   = 2;
  localparam int IN_PATH_OK   = 3;
  localparam int IN_BRAKE_OK  = 4;
  localparam int IN_BRAKE_FIT = 5;

  // ******************************
  // types
  // ******************************
  typedef struct packed {
    logic [31:0] period;
    logic [31:0] delay;
    logic        brake;
  } sst_cfg_t;

  localparam sst_cfg_t CFG_RST = '{SELFTEST_PERIOD_DEF, STOP_DELAY_DEF, 1'b0};

  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_TEST = 2'b10
  } sst_state_t;
endpackage

// file: src/sst_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module sst_sync (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      ce_in,
  // pins and synchronised copy
  input  wire logic [sst_pkg::SYNC_W-1:0] d_in,
  output logic      [sst_pkg::SYNC_W-1:0] q_out
);
  logic [sst_pkg::SYNC_W-1:0] meta_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// file: src/sst_timer.sv
// down counter with reload and a pulse when it reaches zero
`timescale 1ns/1ps
module sst_timer (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // control
  input  wire logic        load_in,
  input  wire logic [31:0] load_val_in,
  input  wire logic        tick_in,
  // state
  output logic      [31:0] count_out,
  output logic             expire_out
);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= sst_pkg::TIMER_RST;
    end else if (ce_in) begin
      if (load_in) begin
        count_out <= load_val_in;
      end else if (tick_in && count_out != sst_pkg::TIMER_RST) begin
        count_out <= count_out - 32'h0000_0001;
      end
    end
  end

  // last step down to zero, not when reloading
  assign expire_out = ce_in && !load_in && tick_in && count_out == 32'h0000_0001;
endmodule

// file: verification/sst_drive_model.sv
// drive pins and controller model answering the switch-off path tests
`timescale 1ns/1ps
module sst_drive_model (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // from the block, slow answer select from the bench
  input  wire logic path_test_in,
  input  wire logic brake_test_in,
  input  wire logic warning_in,
  input  wire logic slow_in,
  // to the block
  output logic      path_ok_out,
  output logic      brake_ok_out,
  output logic      torque_off_req_out
);
  logic [7:0] cnt_reg;
  logic [7:0] stop_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 8'h00;
    end else if (!path_test_in) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hff) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign path_ok_out  = path_test_in && (cnt_reg >= (slow_in ? 8'h28 : 8'h02));
  assign brake_ok_out = path_ok_out && brake_test_in;

  // stop the motor, then select torque removal until the test passes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stop_reg           <= 8'h00;
      torque_off_req_out <= 1'b0;
    end else begin
      stop_reg <= (warning_in && !torque_off_req_out) ? stop_reg + 8'h01 : 8'h00;
      if (path_ok_out) begin
        torque_off_req_out <= 1'b0;
      end else if (stop_reg == 8'h10) begin
        torque_off_req_out <= 1'b1;
      end
    end
  end
endmodule

// file: verification/sst_top_bench.sv
// self-checking bench for the safety stop test sequencer
`timescale 1ns/1ps
module sst_top_bench;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        supply = 1'b1;
  logic        stop1 = 1'b0;
  logic        fit = 1'b1;
  logic        slow = 1'b0;
  logic [31:0] rdat;
  logic        tsel, pok, bok, ptest, btest, stor, fstop, bctl, flag, warn, tflag;
  logic [31:0] ramp;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          i;

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  sst_top #(.MS_CYCLES(4)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr), .wr_data_in(wdat),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .supply_good_in(supply),
    .safe_torque_removal_sel_in(tsel), .safe_stop_one_sel_in(stop1), .path_ok_in(pok),
    .brake_ok_in(bok), .brake_fitted_in(fit), .safe_torque_removal_out(stor),
    .fast_stop_out(fstop),
    .fast_stop_ramp_time_out(ramp), .path_test_out(ptest), .brake_test_out(btest),
    .brake_ctrl_enable_out(bctl), .selftest_required_flag_out(flag),
    .selftest_due_warning_out(warn), .torque_removed_flag_out(tflag));

  sst_drive_model MDL (
    .clk_in(clk_in), .rst_in(rst_in), .path_test_in(ptest), .brake_test_in(btest),
    .warning_in(warn), .slow_in(slow), .path_ok_out(pok), .brake_ok_out(bok),
    .torque_off_req_out(tsel));

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk_in);
    wr   <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 chk(rdat & m, e);
  endtask

  // one full self-test, checked while running and after the pass
  task automatic tcyc(input logic eb);
    for (i = 0; i < 9000 && ptest !== 1'b1; i++) @(negedge clk_in);
    chk(32'(ptest), 32'h1);
    @(negedge clk_in);
    chk(32'(btest), 32'(eb));
    chk(32'(tflag), 32'h1);
    for (i = 0; i < 200 && ptest !== 1'b0; i++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
    chk({30'h0, flag, warn}, 32'h0);
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    tcyc(1'b1);
    rchk(8'h00, 32'hffff_ffff, 32'h0000_7080);
    rchk(8'h10, 32'hffff_ffff, 32'h0);
    rchk(8'h14, 32'hffff_ffff, 32'h0);
    rchk(8'h2c, 32'hffff_ffff, 32'h0);
    wreg(8'h00, 32'h2);
    wreg(8'h04, 32'h8);
    wreg(8'h08, 32'h1);
    wreg(8'h10, 32'h57);
    rchk(8'h24, 32'h80, 32'h80);
    wreg(8'h14, 32'hac);
    rchk(8'h24, 32'h10, 32'h10);
    wreg(8'h1c, 32'h0);
    wreg(8'h20, 32'h0);
    rchk(8'h24, 32'h20, 32'h20);
    wreg(8'h1c, 32'h5);
    wreg(8'h20, 32'h5);
    wreg(8'h18, 32'h5);
    wreg(8'h14, 32'hac);
    rchk(8'h24, 32'h140, 32'h40);
    chk(32'(bctl), 32'h0);
    @(posedge clk_in);
    supply <= 1'b0;
    repeat (6) @(posedge clk_in);
    supply <= 1'b1;
    tcyc(1'b1);
    chk(32'(bctl), 32'h1);
    rchk(8'h28, 32'hffff_ffff, 32'h2);
    wreg(8'h0c, 32'h3);
    @(negedge clk_in);
    chk(ramp, 32'h3);
    @(posedge clk_in);
    stop1 <= 1'b1;
    for (i = 0; i < 10 && fstop !== 1'b1; i++) @(negedge clk_in);
    chk(32'(fstop), 32'h1);
    repeat (20) @(negedge clk_in);
    chk(32'(stor), 32'h0);
    for (i = 0; i < 30 && stor !== 1'b1; i++) @(negedge clk_in);
    chk({30'h0, stor, tflag}, 32'h3);
    @(posedge clk_in);
    stop1 <= 1'b0;
    repeat (6) @(negedge clk_in);
    chk({30'h0, stor, fstop}, 32'h0);
    @(posedge clk_in);
    slow <= 1'b1;
    fit  <= 1'b0;
    for (i = 0; i < 9000 && warn !== 1'b1; i++) @(negedge clk_in);
    chk({29'h0, warn, flag, stor}, 32'h6);
    rchk(8'h24, 32'h6, 32'h6);
    tcyc(1'b0);
    test_done();
  end
endmodule
